// *** common/pisb_pkg.sv ***
// Shared constants and types for the interrupt sense/status/mask bank
package pisb_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_SENSE0 = 8'h07;
  localparam logic [7:0] ADDR_STAT1 = 8'h08;
  localparam logic [7:0] ADDR_MASK1 = 8'h09;
  localparam logic [7:0] ADDR_SENSE1 = 8'h0A;
  localparam logic [7:0] ADDR_STAT3 = 8'h0E;
  localparam logic [7:0] ADDR_MASK3 = 8'h0F;

  // Bus address of the device on the two-wire link; value is arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  // ==========================================================================
  // Field positions, implemented bits and reset values
  localparam int BUCK_A_BIT = 0;
  localparam int BUCK_B_BIT = 3;
  localparam int BUCK_C_BIT = 4;
  localparam int OV_BIT = 2;
  localparam logic [7:0] STAT1_USED = 8'h19;
  localparam logic [7:0] MASK1_WR = 8'h7F;
  localparam logic [7:0] MASK1_RST = 8'h7F;
  localparam logic [7:0] STAT3_USED = 8'h04;
  localparam logic [7:0] MASK3_WR = 8'hC5;
  localparam logic [7:0] MASK3_RST = 8'hC5;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // ==========================================================================
  // Synchronised input vector layout
  localparam int SYNC_W = 15;
  localparam int IN_BUTTON = 0;
  localparam int IN_TESTB = 7;
  localparam int IN_BUCK_A = 8;
  localparam int IN_BUCK_B = 9;
  localparam int IN_BUCK_C = 10;
  localparam int IN_OV = 11;
  localparam int IN_STRAP = 12;
  localparam int IN_SCL = 13;
  localparam int IN_SDA = 14;

  // ==========================================================================
  // Counts
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [2:0] SYNC_FILL = 3'h5;
  localparam logic [2:0] INIT_STEP = 3'h1;

  // ==========================================================================
  // Link state machine and module state
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_WDATA, ST_DATA_ACK, ST_TX, ST_TX_ACK, ST_TX_LOAD
  } pisb_state_e;

  typedef struct packed {
    pisb_state_e st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rdMode;
    logic sdaOe;
    logic sclPrev;
    logic sdaPrev;
    logic [7:0] stat1;
    logic [7:0] mask1;
    logic [7:0] stat3;
    logic [7:0] mask3;
    logic [2:0] initCnt;
    logic initDone;
  } pisb_regs_s;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] out;
  } pisb_sync_s;

endpackage

// *** hdl/pisb_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pisb_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [pisb_pkg::SYNC_W-1:0] rawIn,
  output logic [pisb_pkg::SYNC_W-1:0] syncOut
);
  import pisb_pkg::*;

  pisb_sync_s q;
  pisb_sync_s d;
  logic [SYNC_W-1:0] agree;

  // ==========================================================================
  // Filter: output moves only when stages two and three agree
  always_comb begin
    d = q;
    agree = ~(q.s2 ^ q.s3);
    d.s1 = rawIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.out = (q.s2 & agree) | (q.out & ~agree);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign syncOut = q.out;

endmodule

// *** hdl/pisb_irq_bank.sv ***
// Interrupt sense, status and mask bank with two-wire register access
// Summary of operation
// - Sense bit 0 shows button level
// - Sense bit 1 shows low input detect
// - Sense bits 2-5 show four thermal comparators
// - Sense bit 6 shows test pin A
// - Sense bit 7 shows test pin B
// - Buck overcurrent flags latch, write-one clears
// - Buck masks read-write, bits 0-6 reset one
// - Buck overcurrent sense bits live, read-only
// - Overvoltage flag latches, write-one clears
// - Grounded front supply presets overvoltage flag
// - Overvoltage mask register, fixed zero bits
// - Interrupt line low on any unmasked flag
// - Flags sticky; new event beats clear
// - Masked flags still set; unmask asserts line
// - Sense bits live, unlatched, writes ignored
`timescale 1ns/1ns
module pisb_irq_bank #(
  parameter logic [6:0] DEV_ADDR = pisb_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic powerButtonInput,
  input wire logic lowInputDetect,
  input wire logic [3:0] thermalAbove,
  input wire logic testPinA,
  input wire logic testPinB,
  input wire logic [2:0] buckOvercurrent,
  input wire logic frontSupplyOvervoltage,
  input wire logic frontSupplyGrounded,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic irqLine_n
);
  import pisb_pkg::*;

  localparam pisb_regs_s REGS_RST = '{st: ST_IDLE, mask1: MASK1_RST, mask3: MASK3_RST,
    default: '0};

  pisb_regs_s q;
  pisb_regs_s d;
  logic [SYNC_W-1:0] syn;
  logic [7:0] sense0;
  logic [7:0] sense1;
  logic [7:0] clr1;
  logic [7:0] clr3;
  logic [7:0] set1;
  logic [7:0] set3;
  logic [7:0] txByte;
  logic [7:0] rdByte;
  logic [7:0] tmpShift;
  logic scl;
  logic sda;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic regWr;

  // ==========================================================================
  // Input synchronisation
  pisb_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .rawIn({sdaIn, sclIn, frontSupplyGrounded, frontSupplyOvervoltage, buckOvercurrent,
      testPinB, testPinA, thermalAbove, lowInputDetect, powerButtonInput}),
    .syncOut(syn)
  );

  assign scl = syn[IN_SCL];
  assign sda = syn[IN_SDA];
  assign sense0 = syn[IN_TESTB:IN_BUTTON];

  always_comb begin
    sense1 = BYTE_ZERO;
    sense1[BUCK_A_BIT] = syn[IN_BUCK_A];
    sense1[BUCK_B_BIT] = syn[IN_BUCK_B];
    sense1[BUCK_C_BIT] = syn[IN_BUCK_C];
  end

  // ==========================================================================
  // Read decode; sense reads are live, unmapped reads give zero
  always_comb begin
    if (q.ptr == ADDR_SENSE0) begin
      rdByte = sense0;
    end else if (q.ptr == ADDR_STAT1) begin
      rdByte = q.stat1;
    end else if (q.ptr == ADDR_MASK1) begin
      rdByte = q.mask1;
    end else if (q.ptr == ADDR_SENSE1) begin
      rdByte = sense1;
    end else if (q.ptr == ADDR_STAT3) begin
      rdByte = q.stat3;
    end else if (q.ptr == ADDR_MASK3) begin
      rdByte = q.mask3;
    end else begin
      rdByte = BYTE_ZERO;
    end
  end

  // ==========================================================================
  // Link engine and register update
  always_comb begin
    d = q;
    regWr = 1'b0;
    txByte = rdByte;
    tmpShift = {q.shift[6:0], 1'b0};
    d.sclPrev = scl;
    d.sdaPrev = sda;
    sclRise = scl & ~q.sclPrev;
    sclFall = ~scl & q.sclPrev;
    startCond = q.sclPrev & scl & q.sdaPrev & ~sda;
    stopCond = q.sclPrev & scl & ~q.sdaPrev & sda;

    if (startCond) begin
      d.st = ST_ADDR;
      d.bitCnt = '0;
      d.sdaOe = 1'b0;
    end else if (stopCond) begin
      d.st = ST_IDLE;
      d.sdaOe = 1'b0;
    end else begin
      case (q.st)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (sclRise && q.bitCnt != BYTE_BITS) begin
            d.shift = {q.shift[6:0], sda};
            d.bitCnt = q.bitCnt + BIT_STEP;
          end else if (sclFall && q.bitCnt == BYTE_BITS) begin
            d.sdaOe = 1'b1;
            if (q.st == ST_ADDR) begin
              d.rdMode = q.shift[0];
              d.st = ST_ADDR_ACK;
              if (q.shift[7:1] != DEV_ADDR) begin
                d.st = ST_IDLE;
                d.sdaOe = 1'b0;
              end
            end else if (q.st == ST_PTR) begin
              d.ptr = q.shift;
              d.st = ST_DATA_ACK;
            end else begin
              regWr = 1'b1;
              d.ptr = q.ptr + PTR_STEP;
              d.st = ST_DATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            d.bitCnt = '0;
            if (q.rdMode) begin
              d.shift = txByte;
              d.sdaOe = ~txByte[7];
              d.st = ST_TX;
            end else begin
              d.sdaOe = 1'b0;
              d.st = ST_PTR;
            end
          end
        end
        ST_DATA_ACK: begin
          if (sclFall) begin
            d.sdaOe = 1'b0;
            d.bitCnt = '0;
            d.st = ST_WDATA;
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (q.bitCnt == LAST_BIT) begin
              d.sdaOe = 1'b0;
              d.st = ST_TX_ACK;
            end else begin
              d.shift = tmpShift;
              d.sdaOe = ~tmpShift[7];
              d.bitCnt = q.bitCnt + BIT_STEP;
            end
          end
        end
        ST_TX_ACK: begin
          if (sclRise) begin
            // A not-acknowledge ends the read burst
            d.st = sda ? ST_IDLE : ST_TX_LOAD;
            if (!sda) begin
              d.ptr = q.ptr + PTR_STEP;
            end
          end
        end
        ST_TX_LOAD: begin
          if (sclFall) begin
            d.shift = txByte;
            d.sdaOe = ~txByte[7];
            d.bitCnt = '0;
            d.st = ST_TX;
          end
        end
        default: begin
        end
      endcase
    end

    clr1 = (regWr && q.ptr == ADDR_STAT1) ? q.shift : BYTE_ZERO;
    clr3 = (regWr && q.ptr == ADDR_STAT3) ? q.shift : BYTE_ZERO;
    set1 = BYTE_ZERO;
    set1[BUCK_A_BIT] = syn[IN_BUCK_A];
    set1[BUCK_B_BIT] = syn[IN_BUCK_B];
    set1[BUCK_C_BIT] = syn[IN_BUCK_C];
    set3 = BYTE_ZERO;
    set3[OV_BIT] = syn[IN_OV];

    // Strap is read only once the synchroniser has filled after reset
    if (!q.initDone) begin
      d.initCnt = q.initCnt + INIT_STEP;
      if (q.initCnt == SYNC_FILL) begin
        d.initDone = 1'b1;
        set3[OV_BIT] = syn[IN_OV] | syn[IN_STRAP];
      end
    end

    // Set is ORed in after the clear, so a coincident event survives
    d.stat1 = ((q.stat1 & ~clr1) | set1) & STAT1_USED;
    d.stat3 = ((q.stat3 & ~clr3) | set3) & STAT3_USED;
    if (regWr && q.ptr == ADDR_MASK1) begin
      d.mask1 = q.shift & MASK1_WR;
    end
    if (regWr && q.ptr == ADDR_MASK3) begin
      d.mask3 = q.shift & MASK3_WR;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  assign sdaOut = 1'b0;
  assign sdaOe = q.sdaOe;
  assign irqLine_n = ~(|(q.stat1 & ~q.mask1) | (q.stat3[OV_BIT] & ~q.mask3[OV_BIT]));

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence unmaskSeq;
    q.stat3[OV_BIT] && q.mask3[OV_BIT] ##1 q.stat3[OV_BIT] && !q.mask3[OV_BIT];
  endsequence

  sequence bootSeq;
    !q.initDone ##1 q.initDone;
  endsequence

  sequence senseLoadSeq;
    (q.st == ST_TX_LOAD || (q.st == ST_ADDR_ACK && q.rdMode)) && sclFall && !startCond
      && !stopCond && q.ptr == ADDR_SENSE0;
  endsequence

  eventLatch_a: assert property (syn[IN_BUCK_A] |=> q.stat1[BUCK_A_BIT])
    else $error("buck overcurrent event not latched");
  clearWorks_a: assert property ((q.stat1[BUCK_A_BIT] && clr1[BUCK_A_BIT] && !syn[IN_BUCK_A])
    |=> !q.stat1[BUCK_A_BIT])
    else $error("write one did not clear buck flag");
  stickyFlag_a: assert property ((q.stat1[BUCK_B_BIT] && !clr1[BUCK_B_BIT])
    |=> q.stat1[BUCK_B_BIT])
    else $error("buck flag dropped without clear");
  setWins_a: assert property ((clr1[BUCK_C_BIT] && syn[IN_BUCK_C]) |=> q.stat1[BUCK_C_BIT])
    else $error("clear beat a coincident event");
  ovLatch_a: assert property (syn[IN_OV] |=> q.stat3[OV_BIT])
    else $error("overvoltage event not latched");
  strapInit_a: assert property (bootSeq |-> (q.stat3[OV_BIT] || !$past(syn[IN_STRAP])))
    else $error("grounded front supply did not preset flag");
  fixedBits_a: assert property (((q.mask1 & ~MASK1_WR) == BYTE_ZERO)
    && ((q.mask3 & ~MASK3_WR) == BYTE_ZERO))
    else $error("fixed mask bit not zero");
  unusedZero_a: assert property (((q.stat1 & ~STAT1_USED) == BYTE_ZERO)
    && ((q.stat3 & ~STAT3_USED) == BYTE_ZERO))
    else $error("unused status bit set");
  maskWrite_a: assert property ((regWr && q.ptr == ADDR_MASK1)
    |=> q.mask1 == ($past(q.shift) & MASK1_WR))
    else $error("mask write not stored");
  unmaskIrq_a: assert property (unmaskSeq |-> !irqLine_n)
    else $error("unmasking a set flag left line high");
  senseRead_a: assert property (senseLoadSeq |=> q.shift == $past(sense0))
    else $error("sense read not live");

endmodule

// *** test/pisb_bus_model.sv ***
// Host-side two-wire bus lines with the SDA pull-up
`timescale 1ns/1ns
module pisb_bus_model (
  input wire logic hostSdaLow,
  input wire logic devSdaOe,
  input wire logic devSdaOut,
  output logic sdaWire
);
  // Open drain: any party pulling low wins, the pull-up otherwise
  assign sdaWire = !(hostSdaLow || (devSdaOe && !devSdaOut));
endmodule

// *** test/tb_top.sv ***
// Register-level testbench for the interrupt sense/status/mask bank
`timescale 1ns/1ns
module tb_top;
  import pisb_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic btn = 1'b0, lowIn = 1'b0, tA = 1'b0, tB = 1'b0, ovIn = 1'b0, strap = 1'b1;
  logic scl = 1'b1, hostLow = 1'b0;
  logic [3:0] therm = 4'h0;
  logic [2:0] buck = 3'h0;
  logic sdaOut, sdaOe, irqLine_n, sdaWire;
  logic [7:0] pat;
  int nMismatch = 0;
  int nCompared = 0;

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  pisb_irq_bank u_pisb_irq_bank (.clk_sys(clk_sys), .rst(rst), .powerButtonInput(btn),
    .lowInputDetect(lowIn), .thermalAbove(therm), .testPinA(tA), .testPinB(tB),
    .buckOvercurrent(buck), .frontSupplyOvervoltage(ovIn), .frontSupplyGrounded(strap),
    .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .irqLine_n(irqLine_n));
  pisb_bus_model u_pisb_bus_model (.hostSdaLow(hostLow), .devSdaOe(sdaOe),
    .devSdaOut(sdaOut), .sdaWire(sdaWire));

  // ==========================================================================
  // Bus cycle helpers
  task automatic waitClk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Short gap after SCL fall so SDA never moves in the same cycle as SCL
  task automatic putBit(input logic b, output logic seen);
    waitClk(2);
    hostLow <= !b;
    waitClk(10);
    scl <= 1'b1;
    waitClk(6);
    seen = sdaWire;
    waitClk(6);
    scl <= 1'b0;
  endtask

  task automatic start;
    waitClk(2);
    hostLow <= 1'b0;
    waitClk(12);
    scl <= 1'b1;
    waitClk(12);
    hostLow <= 1'b1;
    waitClk(12);
    scl <= 1'b0;
  endtask

  task automatic stop;
    waitClk(2);
    hostLow <= 1'b1;
    waitClk(12);
    scl <= 1'b1;
    waitClk(12);
    hostLow <= 1'b0;
    waitClk(12);
  endtask

  task automatic sendB(input logic [7:0] d, input logic ackExp);
    logic s;
    for (int i = 7; i >= 0; i--) putBit(d[i], s);
    putBit(1'b1, s);
    chk("ack", {7'h00, s}, {7'h00, ackExp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start;
    sendB({DEV_ADDR_DEFAULT, 1'b0}, 1'b0);
    sendB(a, 1'b0);
    sendB(d, 1'b0);
    stop;
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic s;
    start;
    sendB({DEV_ADDR_DEFAULT, 1'b0}, 1'b0);
    sendB(a, 1'b0);
    start;
    sendB({DEV_ADDR_DEFAULT, 1'b1}, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      putBit(1'b1, s);
      d[i] = s;
    end
    putBit(1'b1, s);
    stop;
    chk(name, d, exp);
  endtask

  // Burst write of two bytes: exercises the pointer auto-increment
  task automatic wr2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
    start;
    sendB({DEV_ADDR_DEFAULT, 1'b0}, 1'b0);
    sendB(a, 1'b0);
    sendB(d0, 1'b0);
    sendB(d1, 1'b0);
    stop;
  endtask

  // Burst read of two bytes: host acknowledges the first, refuses the second
  task automatic rd2(input logic [7:0] a, input logic [7:0] exp0, input logic [7:0] exp1);
    logic [15:0] d;
    logic s;
    start;
    sendB({DEV_ADDR_DEFAULT, 1'b0}, 1'b0);
    sendB(a, 1'b0);
    start;
    sendB({DEV_ADDR_DEFAULT, 1'b1}, 1'b0);
    for (int i = 15; i >= 0; i--) begin
      putBit(1'b1, s);
      d[i] = s;
      if (i == 8) putBit(1'b0, s);
    end
    putBit(1'b1, s);
    stop;
    chk("burst first", d[15:8], exp0);
    chk("burst second", d[7:0], exp1);
  endtask

  task automatic irqIs(input logic exp);
    chk("irq", {7'h00, irqLine_n}, {7'h00, exp});
  endtask

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", nCompared, nMismatch);
    if (nMismatch == 0 && nCompared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    waitClk(2);
    rst <= 1'b0;
    waitClk(20);
    rdc("mask1", ADDR_MASK1, 8'h7F);
    rdc("mask3", ADDR_MASK3, 8'hC5);
    rdc("stat1", ADDR_STAT1, 8'h00);
    rdc("stat3", ADDR_STAT3, 8'h04);
    irqIs(1'b1);
    for (int k = 0; k < 2; k++) begin
      pat = k ? 8'h5A : 8'hA5;
      {tB, tA, therm, lowIn, btn} <= pat;
      waitClk(10);
      wr(ADDR_SENSE0, ~pat);
      rdc("sense0", ADDR_SENSE0, pat);
    end
    // Foreign address must be left unanswered
    start;
    sendB({7'h15, 1'b0}, 1'b1);
    stop;
    rdc("unmapped", 8'h20, 8'h00);
    buck <= 3'h5;
    waitClk(10);
    rdc("sense1", ADDR_SENSE1, 8'h11);
    buck <= 3'h0;
    waitClk(10);
    rdc("sense1", ADDR_SENSE1, 8'h00);
    rdc("stat1", ADDR_STAT1, 8'h11);
    irqIs(1'b1);
    wr(ADDR_MASK1, 8'h80);
    rdc("mask1", ADDR_MASK1, 8'h00);
    irqIs(1'b0);
    wr(ADDR_STAT1, 8'h00);
    rdc("stat1", ADDR_STAT1, 8'h11);
    wr(ADDR_STAT1, 8'h01);
    rdc("stat1", ADDR_STAT1, 8'h10);
    irqIs(1'b0);
    // Buck C still active while its clear lands: the set must win
    buck <= 3'h6;
    wr(ADDR_STAT1, 8'h10);
    buck <= 3'h0;
    waitClk(10);
    rdc("stat1", ADDR_STAT1, 8'h18);
    irqIs(1'b0);
    wr(ADDR_STAT1, 8'h08);
    rdc("stat1", ADDR_STAT1, 8'h10);
    irqIs(1'b0);
    wr(ADDR_STAT1, 8'h10);
    rdc("stat1", ADDR_STAT1, 8'h00);
    irqIs(1'b1);
    // Preset overvoltage flag still set: unmasking pulls the line
    wr(ADDR_MASK3, 8'hC1);
    irqIs(1'b0);
    wr(ADDR_MASK3, 8'hC5);
    irqIs(1'b1);
    wr(ADDR_STAT3, 8'h04);
    rdc("stat3", ADDR_STAT3, 8'h00);
    wr(ADDR_MASK3, 8'hFF);
    rdc("mask3", ADDR_MASK3, 8'hC5);
    wr(ADDR_MASK3, 8'h00);
    rdc("mask3", ADDR_MASK3, 8'h00);
    irqIs(1'b1);
    ovIn <= 1'b1;
    waitClk(10);
    ovIn <= 1'b0;
    waitClk(10);
    irqIs(1'b0);
    rdc("stat3", ADDR_STAT3, 8'h04);
    wr(ADDR_STAT3, 8'h04);
    irqIs(1'b1);
    wr2(ADDR_MASK1, 8'h19, 8'hFF);
    rd2(ADDR_MASK1, 8'h19, 8'h00);
    rd2(8'h06, 8'h00, pat);
    // Second reset with the front supply powered: no preset this time
    strap <= 1'b0;
    rst <= 1'b1;
    waitClk(2);
    rst <= 1'b0;
    waitClk(20);
    rdc("stat3", ADDR_STAT3, 8'h00);
    rdc("mask1", ADDR_MASK1, 8'h7F);
    rdc("mask3", ADDR_MASK3, 8'hC5);
    irqIs(1'b1);
    print_verdict;
  end

  // Roughly twice the expected run length
  initial begin
    waitClk(80000);
    nMismatch++;
    print_verdict;
  end
endmodule
